//--- logic/smnu_unit.sv
// execution datapath for the logical shifts, unsigned multiply and negate
// assumes the sequencer gives the opcode in cycle 1 with start, the prefix flag,
// the effective address and the memory operand once read; the unit owns the cycle count
`timescale 1ns/10ps

// Notes on behaviour
// - byte shift left, zero in, msb to carry
// - n from bit 7, z all clear
// - left shift overflow is n xor c
// - decode byte shift left opcodes and prefix
// - memory forms read-modify-write, 6 or 7 cycles
// - accumulator forms take two cycles
// - double shift left, n bit 15, z
// - double left carry from old bit 15
// - double left opcode 05, three cycles
// - byte shift right, n cleared, carry bit 0
// - right shift overflow equals carry
// - double shift right, carry old bit 0
// - double right overflow equals carry
// - double right opcode 04, three cycles
// - multiply a by b unsigned into double
// - multiply opcode 3d, ten cycles
// - negate is zero minus operand
// - negate overflow at 80, carry unless zero
module smnu_unit
    import smnu_pkg::*;
(
    mclk,
    rst,
    start,
    prefix_y,
    opcode,
    eff_addr,
    mem_rdata,
    init_regs,
    init_load,
    busy,
    done,
    illegal,
    bus,
    regs
);
    input wire logic mclk;
    input wire logic rst;
    input wire logic start;
    input wire logic prefix_y;
    input wire logic [7:0] opcode;
    input wire logic [15:0] eff_addr;
    input wire logic [7:0] mem_rdata;
    input wire smnu_regs_t init_regs;
    input wire logic init_load;
    output logic busy;
    output logic done;
    output logic illegal;
    output smnu_bus_t bus;
    output smnu_regs_t regs;

    typedef struct packed {
        smnu_state_t state;
        smnu_op_t op;
        smnu_src_t src;
        logic [3:0] cyc;
        logic [3:0] last;
        logic [7:0] operand;
        logic done;
        logic illegal;
        smnu_bus_t bus;
        smnu_regs_t regs;
    } smnu_st_t;

    // whole state after reset: idle, bus parked on the idle address
    localparam smnu_st_t ST_RESET = '{
        state: SMNU_IDLE,
        op: SMNU_NONE,
        src: SMNU_SRC_A,
        cyc: CYC_ACC,
        last: CYC_ACC,
        operand: BYTE_ZERO,
        done: 1'b0,
        illegal: 1'b0,
        bus: '{
            idle: 1'b0,
            write: 1'b0,
            addr: IDLE_ADDR,
            wdata: BYTE_ZERO
        },
        regs: '{
            acc_a: BYTE_ZERO,
            acc_b: BYTE_ZERO,
            condition_code_reg: BYTE_ZERO
        }
    };

    smnu_st_t st_reg;
    smnu_st_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // decode
    smnu_op_t dec_op;
    smnu_src_t dec_src;
    logic [3:0] dec_len;

    always_comb begin
        dec_op = SMNU_NONE;
        dec_src = SMNU_SRC_A;
        dec_len = CYC_ACC;
        unique case (opcode)
            OP_SHL_A, OP_SHR_A, OP_NEG_A: begin
                dec_src = SMNU_SRC_A;
                dec_len = CYC_ACC;
            end
            OP_SHL_B, OP_SHR_B, OP_NEG_B: begin
                dec_src = SMNU_SRC_B;
                dec_len = CYC_ACC;
            end
            OP_SHL_EXT, OP_SHR_EXT, OP_NEG_EXT, OP_SHL_IDX, OP_SHR_IDX, OP_NEG_IDX: begin
                dec_src = SMNU_SRC_MEM;
                dec_len = prefix_y ? CYC_MEM_Y : CYC_MEM;
            end
            OP_SHL_D, OP_SHR_D: begin
                dec_src = SMNU_SRC_D;
                dec_len = CYC_DBL;
            end
            OP_MUL: begin
                dec_src = SMNU_SRC_D;
                dec_len = CYC_MUL;
            end
            default: begin
                dec_src = SMNU_SRC_A;
                dec_len = CYC_ACC;
            end
        endcase
        unique case (opcode)
            OP_SHL_A, OP_SHL_B, OP_SHL_EXT, OP_SHL_IDX: dec_op = SMNU_SHL;
            OP_SHR_A, OP_SHR_B, OP_SHR_EXT, OP_SHR_IDX: dec_op = SMNU_SHR;
            OP_NEG_A, OP_NEG_B, OP_NEG_EXT, OP_NEG_IDX: dec_op = SMNU_NEG;
            OP_SHL_D: dec_op = SMNU_SHLD;
            OP_SHR_D: dec_op = SMNU_SHRD;
            OP_MUL: dec_op = SMNU_MUL;
            default: dec_op = SMNU_NONE;
        endcase
        // the y prefix only exists for the indexed memory forms
        if (prefix_y && opcode != OP_SHL_IDX && opcode != OP_SHR_IDX && opcode != OP_NEG_IDX) begin
            dec_op = SMNU_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result and flags
    logic [7:0] opnd;
    logic [15:0] dacc;
    logic [7:0] res8;
    logic [15:0] res16;
    logic [15:0] prod;
    logic [7:0] ccr_new;
    logic [15:0] shl16;
    logic [15:0] shr16;
    logic [7:0] shl8;
    logic [7:0] shr8;

    always_comb begin
        unique case (st_reg.src)
            SMNU_SRC_B: opnd = st_reg.regs.acc_b;
            SMNU_SRC_MEM: opnd = st_reg.operand;
            SMNU_SRC_A, SMNU_SRC_D: opnd = st_reg.regs.acc_a;
        endcase
        dacc = {st_reg.regs.acc_a, st_reg.regs.acc_b};
    end

    // shift network, one slice per bit of the double accumulator;
    // the low eight slices also shift the byte operand
    for (genvar i = 0; i < 16; i++) begin : g_bit
        if (i == 0) begin : g_lsb
            assign shl16[i] = 1'b0;
        end else begin : g_up
            assign shl16[i] = dacc[i - 1];
        end
        if (i == 15) begin : g_msb
            assign shr16[i] = 1'b0;
        end else begin : g_down
            assign shr16[i] = dacc[i + 1];
        end
        if (i < 8) begin : g_byte
            if (i == 0) begin : g_blsb
                assign shl8[i] = 1'b0;
            end else begin : g_bup
                assign shl8[i] = opnd[i - 1];
            end
            if (i == 7) begin : g_bmsb
                assign shr8[i] = 1'b0;
            end else begin : g_bdown
                assign shr8[i] = opnd[i + 1];
            end
        end
    end

    always_comb begin
        prod = 16'(st_reg.regs.acc_a) * 16'(st_reg.regs.acc_b);
        res8 = opnd;
        res16 = dacc;
        ccr_new = st_reg.regs.condition_code_reg;
        unique case (st_reg.op)
            SMNU_SHL: begin
                res8 = shl8;
                ccr_new[CC_C] = opnd[7];
                ccr_new[CC_N] = res8[7];
                ccr_new[CC_Z] = (res8 == BYTE_ZERO);
                ccr_new[CC_V] = res8[7] ^ opnd[7];
            end
            SMNU_SHR: begin
                res8 = shr8;
                ccr_new[CC_C] = opnd[0];
                ccr_new[CC_N] = 1'b0;
                ccr_new[CC_Z] = (res8 == BYTE_ZERO);
                ccr_new[CC_V] = opnd[0];
            end
            SMNU_NEG: begin
                res8 = 8'(BYTE_ZERO - opnd);
                ccr_new[CC_N] = res8[7];
                ccr_new[CC_Z] = (res8 == BYTE_ZERO);
                ccr_new[CC_V] = (opnd == NEG_LIMIT);
                ccr_new[CC_C] = (opnd != BYTE_ZERO);
            end
            SMNU_SHLD: begin
                res16 = shl16;
                ccr_new[CC_C] = dacc[15];
                ccr_new[CC_N] = res16[15];
                ccr_new[CC_Z] = (res16 == WORD_ZERO);
                ccr_new[CC_V] = res16[15] ^ dacc[15];
            end
            SMNU_SHRD: begin
                res16 = shr16;
                ccr_new[CC_C] = dacc[0];
                ccr_new[CC_N] = 1'b0;
                ccr_new[CC_Z] = (res16 == WORD_ZERO);
                ccr_new[CC_V] = dacc[0];
            end
            SMNU_MUL: begin
                res16 = prod;
                ccr_new[CC_C] = prod[7];
            end
            SMNU_NONE: begin
                res8 = opnd;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus plan for the current step; each flag is registered onto the bus,
    // so the bus shows it one step later
    logic mem_form;
    logic mem_y;
    logic [3:0] read_cyc;
    logic addr_step;
    logic read_step;
    logic write_step;
    logic dbl_idle_step;

    always_comb begin
        mem_form = (st_reg.src == SMNU_SRC_MEM);
        mem_y = (st_reg.last == CYC_MEM_Y);
        // operand on the bus in step 4, or 5 when the prefix took a fetch
        read_cyc = mem_y ? CYC_MEM - CYC_ONE : CYC_MEM - CYC_ACC;
        addr_step = mem_form && (st_reg.cyc == read_cyc - CYC_ONE);
        read_step = mem_form && (st_reg.cyc == read_cyc);
        write_step = mem_form && (st_reg.cyc == st_reg.last - CYC_ONE);
        dbl_idle_step = (st_reg.src == SMNU_SRC_D) && (st_reg.cyc != st_reg.last);
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle sequencing
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.illegal = 1'b0;
        if (init_load && st_reg.state == SMNU_IDLE) begin
            st_next.regs = init_regs;
        end
        unique case (st_reg.state)
            SMNU_IDLE: begin
                st_next.bus.idle = 1'b0;
                st_next.bus.write = 1'b0;
                if (start) begin
                    if (dec_op == SMNU_NONE) begin
                        st_next.illegal = 1'b1;
                    end else begin
                        st_next.state = SMNU_RUN;
                        st_next.op = dec_op;
                        st_next.src = dec_src;
                        st_next.last = dec_len;
                        st_next.cyc = CYC_ACC;
                    end
                end
            end
            SMNU_RUN: begin
                st_next.bus.idle = 1'b0;
                st_next.bus.write = 1'b0;
                st_next.bus.addr = IDLE_ADDR;
                if (read_step) begin
                    st_next.operand = mem_rdata;
                    st_next.bus.idle = 1'b1;
                end
                if (addr_step) begin
                    st_next.bus.addr = eff_addr;
                end
                if (write_step) begin
                    st_next.bus.write = 1'b1;
                    st_next.bus.addr = eff_addr;
                    st_next.bus.wdata = res8;
                end
                if (dbl_idle_step) begin
                    st_next.bus.idle = 1'b1;
                end
                if (st_reg.cyc == st_reg.last) begin
                    st_next.state = SMNU_IDLE;
                    st_next.done = 1'b1;
                    st_next.regs.condition_code_reg = ccr_new;
                    unique case (st_reg.src)
                        SMNU_SRC_A: st_next.regs.acc_a = res8;
                        SMNU_SRC_B: st_next.regs.acc_b = res8;
                        SMNU_SRC_D: {st_next.regs.acc_a, st_next.regs.acc_b} = res16;
                        SMNU_SRC_MEM: st_next.regs.acc_a = st_reg.regs.acc_a;
                    endcase
                end else begin
                    st_next.cyc = 4'(st_reg.cyc + CYC_ONE);
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = (st_reg.state == SMNU_RUN);
    assign done = st_reg.done;
    assign illegal = st_reg.illegal;
    assign bus = st_reg.bus;
    assign regs = st_reg.regs;
endmodule : smnu_unit

//--- shared/smnu_pkg.sv
// package for the shift, multiply and negate execution unit
// assumes a cpu sequencer that presents opcodes and memory operands
package smnu_pkg;
    localparam logic [7:0] OP_PREFIX_Y = 8'h18;
    localparam logic [7:0] OP_SHL_A = 8'h48;
    localparam logic [7:0] OP_SHL_B = 8'h58;
    localparam logic [7:0] OP_SHL_EXT = 8'h78;
    localparam logic [7:0] OP_SHL_IDX = 8'h68;
    localparam logic [7:0] OP_SHR_A = 8'h44;
    localparam logic [7:0] OP_SHR_B = 8'h54;
    localparam logic [7:0] OP_SHR_EXT = 8'h74;
    localparam logic [7:0] OP_SHR_IDX = 8'h64;
    localparam logic [7:0] OP_NEG_A = 8'h40;
    localparam logic [7:0] OP_NEG_B = 8'h50;
    localparam logic [7:0] OP_NEG_EXT = 8'h70;
    localparam logic [7:0] OP_NEG_IDX = 8'h60;
    localparam logic [7:0] OP_SHL_D = 8'h05;
    localparam logic [7:0] OP_SHR_D = 8'h04;
    localparam logic [7:0] OP_MUL = 8'h3d;
    localparam logic [15:0] IDLE_ADDR = 16'hffff;
    localparam logic [7:0] NEG_LIMIT = 8'h80;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [3:0] CYC_ACC = 4'h2;
    localparam logic [3:0] CYC_DBL = 4'h3;
    localparam logic [3:0] CYC_MEM = 4'h6;
    localparam logic [3:0] CYC_MEM_Y = 4'h7;
    localparam logic [3:0] CYC_MUL = 4'ha;
    localparam logic [3:0] CYC_ONE = 4'h1;
    // condition code bit positions
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;

    typedef enum {
        SMNU_NONE, SMNU_SHL, SMNU_SHR, SMNU_NEG, SMNU_SHLD, SMNU_SHRD, SMNU_MUL
    } smnu_op_t;

    typedef enum {
        SMNU_SRC_A, SMNU_SRC_B, SMNU_SRC_MEM, SMNU_SRC_D
    } smnu_src_t;

    typedef enum {
        SMNU_IDLE, SMNU_RUN
    } smnu_state_t;

    // bus cycle request toward the memory bus
    typedef struct packed {
        logic idle;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } smnu_bus_t;

    typedef struct packed {
        logic [7:0] acc_a;
        logic [7:0] acc_b;
        logic [7:0] condition_code_reg;
    } smnu_regs_t;
endpackage : smnu_pkg

//--- sim/smnu_memory.sv
// memory bus model facing the execution unit
// assumes one operand byte per instruction, given by the bench
`timescale 1ns/10ps
module smnu_memory
    import smnu_pkg::*;
(
    input wire logic mclk,
    input wire smnu_bus_t bus,
    input wire logic [7:0] operand,
    output logic [7:0] mem_rdata,
    output logic [7:0] wr_data,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_count
);
    logic [7:0] junk_reg = 8'h5a;
    initial wr_count = 8'h00;
    // outside a read the data lines carry a changing pattern
    assign mem_rdata = (!bus.write && bus.addr != IDLE_ADDR) ? operand : junk_reg;
    always @(posedge mclk) begin
        junk_reg <= ~junk_reg;
        if (bus.write) begin
            wr_data <= bus.wdata;
            wr_addr <= bus.addr;
            wr_count <= wr_count + 8'h01;
        end
    end
endmodule : smnu_memory

//--- sim/smnu_monitor.sv
// timing and flag checks on the execution unit ports
// assumes mclk and synchronous active high rst
`timescale 1ns/10ps
module smnu_monitor
    import smnu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic prefix_y,
    input wire logic [7:0] opcode,
    input wire logic [15:0] eff_addr,
    input wire logic init_load,
    input wire logic busy,
    input wire logic done,
    input wire logic illegal,
    input wire smnu_bus_t bus,
    input wire smnu_regs_t regs
);
    logic [4:0] cnt_reg;
    logic [4:0] len_reg;
    logic [7:0] op_reg;
    logic [15:0] prod_reg;
    function automatic logic [4:0] op_len(input logic [7:0] op, input logic pf);
        if (pf && op[5:4] != 2'b10) return 5'h00;
        case (op)
            OP_SHL_A, OP_SHL_B, OP_SHR_A, OP_SHR_B, OP_NEG_A, OP_NEG_B: return 5'(CYC_ACC);
            OP_SHL_D, OP_SHR_D: return 5'(CYC_DBL);
            OP_MUL: return 5'(CYC_MUL);
            OP_SHL_EXT, OP_SHR_EXT, OP_NEG_EXT: return 5'(CYC_MEM);
            OP_SHL_IDX, OP_SHR_IDX, OP_NEG_IDX: return pf ? 5'(CYC_MEM_Y) : 5'(CYC_MEM);
            default: return 5'h00;
        endcase
    endfunction : op_len
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= 5'h00;
            len_reg <= 5'h00;
        end else if (start && !busy && op_len(opcode, prefix_y) != 5'h00) begin
            cnt_reg <= 5'h01;
            len_reg <= op_len(opcode, prefix_y);
            op_reg <= opcode;
            prod_reg <= 16'(regs.acc_a) * 16'(regs.acc_b);
        end else if (done) begin
            cnt_reg <= 5'h00;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_done_length: assert property (done |-> cnt_reg == len_reg)
        else $error("done at wrong cycle");
    a_done_late: assert property (cnt_reg <= len_reg)
        else $error("done missing");
    a_read_cycle: assert property (!bus.write && bus.addr != IDLE_ADDR |->
        bus.addr == eff_addr && cnt_reg == len_reg - 5'h03)
        else $error("operand read at wrong cycle or address");
    a_idle_run: assert property (busy && cnt_reg >= 5'h02 && (op_reg[7:4] == 4'h0 || op_reg == OP_MUL) |->
        bus.idle)
        else $error("idle cycle missing");
    a_idle_addr: assert property (bus.idle |-> bus.addr == IDLE_ADDR && !bus.write)
        else $error("idle cycle not at idle address");
    a_write_addr: assert property (bus.write |-> bus.addr == eff_addr && op_reg[6:5] == 2'b11)
        else $error("bad write back");
    a_shl_overflow: assert property (done && (op_reg[3:0] == 4'h8 || op_reg == OP_SHL_D) |->
        regs.condition_code_reg[CC_V] == (regs.condition_code_reg[CC_N] ^ regs.condition_code_reg[CC_C]))
        else $error("left shift overflow wrong");
    a_shr_flags: assert property (done && op_reg[3:0] == 4'h4 |->
        !regs.condition_code_reg[CC_N] && regs.condition_code_reg[CC_V] == regs.condition_code_reg[CC_C])
        else $error("right shift flags wrong");
    a_mul_result: assert property (done && op_reg == OP_MUL |->
        {regs.acc_a, regs.acc_b} == prod_reg && regs.condition_code_reg[CC_C] == prod_reg[7])
        else $error("product wrong");
    a_neg_flags: assert property (done && op_reg == OP_NEG_A |-> regs.condition_code_reg[CC_C] == (regs.acc_a != BYTE_ZERO)
        && regs.condition_code_reg[CC_V] == (regs.acc_a == NEG_LIMIT))
        else $error("negate flags wrong");
    a_high_flags: assert property (!$past(init_load) |-> $stable(regs.condition_code_reg[7:4]))
        else $error("upper flags changed");
    c_mul: cover property (done && op_reg == OP_MUL);
    c_write: cover property (bus.write);
    c_illegal: cover property (illegal);
    c_write_y: cover property (bus.write && len_reg == 5'(CYC_MEM_Y));
endmodule : smnu_monitor
bind smnu_unit smnu_monitor smnu_monitor_i (.mclk(mclk), .rst(rst), .start(start), .prefix_y(prefix_y),
    .opcode(opcode), .eff_addr(eff_addr), .init_load(init_load), .busy(busy), .done(done),
    .illegal(illegal), .bus(bus), .regs(regs));

//--- sim/test_shift_multiply_negate_unit.sv
// self-checking bench for the shift, multiply and negate unit
// assumes the memory model answers operand reads
`timescale 1ns/10ps
module test_shift_multiply_negate_unit
    import smnu_pkg::*;
;
    logic mclk = 0, rst = 1, start = 0, prefix_y = 0, init_load = 0, busy, done, illegal;
    logic [7:0] opcode = 8'h00, operand = 8'h00, mem_rdata, wr_data, wr_count;
    logic [15:0] eff_addr = 16'h0000, wr_addr;
    smnu_regs_t init_regs = '0, regs;
    smnu_bus_t bus;
    int miscompares = 0, total_checks = 0, cycles = 0;
    localparam logic [7:0] OPS [15] = '{OP_SHL_A, OP_SHL_B, OP_SHL_EXT, OP_SHL_IDX, OP_SHR_A, OP_SHR_B,
        OP_SHR_EXT, OP_SHR_IDX, OP_NEG_A, OP_NEG_B, OP_NEG_EXT, OP_NEG_IDX, OP_SHL_D, OP_SHR_D, OP_MUL};
    smnu_unit smnu_unit_i (.mclk(mclk), .rst(rst), .start(start), .prefix_y(prefix_y), .opcode(opcode),
        .eff_addr(eff_addr), .mem_rdata(mem_rdata), .init_regs(init_regs), .init_load(init_load),
        .busy(busy), .done(done), .illegal(illegal), .bus(bus), .regs(regs));
    smnu_memory smnu_memory_i (.mclk(mclk), .bus(bus), .operand(operand), .mem_rdata(mem_rdata),
        .wr_data(wr_data), .wr_addr(wr_addr), .wr_count(wr_count));
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            test_done;
        end
    end
    task test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic check_regs(input string name, input smnu_regs_t e, input smnu_regs_t g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : check_regs
    task automatic check_val(input string name, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : check_val
    function automatic logic legal(input logic [7:0] op, input logic pf);
        legal = 1'b0;
        foreach (OPS[i]) if (OPS[i] == op) legal = !pf || op[7:4] == 4'h6;
    endfunction : legal
    function automatic smnu_regs_t model(input logic [7:0] op, input smnu_regs_t r, input logic [7:0] m,
        output logic [7:0] w);
        smnu_regs_t e;
        logic [15:0] d;
        logic [7:0] x;
        logic c;
        e = r;
        d = {r.acc_a, r.acc_b};
        x = op[5:4] == 2'b00 ? r.acc_a : op[5:4] == 2'b01 ? r.acc_b : m;
        w = 8'h00;
        if (op == OP_MUL) begin
            d = 16'(r.acc_a) * 16'(r.acc_b);
            {e.acc_a, e.acc_b} = d;
            e.condition_code_reg[CC_C] = d[7];
        end else if (op[7:4] == 4'h0) begin
            c = op == OP_SHL_D ? d[15] : d[0];
            d = op == OP_SHL_D ? d << 1 : d >> 1;
            e.condition_code_reg[3:0] = {d[15], d == WORD_ZERO, d[15] ^ c, c};
            {e.acc_a, e.acc_b} = d;
        end else begin
            c = op[3:0] == 4'h8 ? x[7] : op[3:0] == 4'h4 ? x[0] : x != BYTE_ZERO;
            x = op[3:0] == 4'h8 ? x << 1 : op[3:0] == 4'h4 ? x >> 1 : BYTE_ZERO - x;
            e.condition_code_reg[3:0] = {x[7], x == BYTE_ZERO, op[3:0] == 4'h0 ? x == NEG_LIMIT : x[7] ^ c, c};
            if (op[5:4] == 2'b00) e.acc_a = x;
            else if (op[5:4] == 2'b01) e.acc_b = x;
            else w = x;
        end
        return e;
    endfunction : model
    task automatic run_op(input logic [7:0] op, input logic pf, input smnu_regs_t r, input logic [7:0] m);
        smnu_regs_t e;
        logic [7:0] w, cnt0;
        logic ok, seen, mem;
        int n;
        ok = legal(op, pf);
        mem = ok && op[6:5] == 2'b11;
        e = ok ? model(op, r, m, w) : r;
        @(negedge mclk);
        init_regs = r;
        init_load = 1;
        operand = m;
        eff_addr = {1'b0, 15'($urandom)};
        @(negedge mclk);
        init_load = 0;
        start = 1;
        opcode = op;
        prefix_y = pf;
        cnt0 = wr_count;
        @(negedge mclk);
        seen = illegal;
        start = ok;
        opcode = OP_NEG_A;
        prefix_y = 0;
        @(negedge mclk);
        start = 0;
        n = 0;
        while (ok && done !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        check_val("done", {15'h0000, ok}, {15'h0000, ok && done === 1'b1});
        check_val("illegal", {15'h0000, !ok}, {15'h0000, seen});
        check_regs("regs", e, regs);
        check_val("writes", {8'h00, 8'(cnt0 + 8'(mem))}, {8'h00, wr_count});
        if (mem) begin
            check_val("wdata", {8'h00, w}, {8'h00, wr_data});
            check_val("waddr", eff_addr, wr_addr);
        end
        $display("test op %h prefix %0d ended", op, pf);
    endtask : run_op
    initial begin
        void'($urandom(32'h1525_6fd2));
        repeat (16) @(negedge mclk);
        rst = 0;
        run_op(OP_NEG_A, 0, 24'h80_0000, 8'h00);
        run_op(OP_NEG_B, 0, 24'h1200_f0, 8'h00);
        run_op(OP_MUL, 0, 24'hffff_00, 8'h00);
        run_op(OP_SHL_D, 0, 24'h80_0000, 8'h00);
        run_op(OP_SHR_D, 0, 24'h0001_00, 8'h00);
        run_op(OP_SHL_IDX, 1, 24'h00_0000, 8'h80);
        run_op(OP_SHR_IDX, 1, 24'h00_0000, 8'h01);
        run_op(OP_NEG_EXT, 0, 24'h00_0000, 8'h80);
        run_op(8'h01, 0, 24'h5aa5_f3, 8'h00);
        run_op(OP_SHL_A, 1, 24'h5aa5_f3, 8'h00);
        // reset in the middle of a multiply: unit idle, registers cleared
        @(negedge mclk);
        init_regs = 24'h1234_5f;
        init_load = 1;
        @(negedge mclk);
        init_load = 0;
        start = 1;
        opcode = OP_MUL;
        @(negedge mclk);
        start = 0;
        repeat (3) @(negedge mclk);
        rst = 1;
        repeat (2) @(negedge mclk);
        rst = 0;
        check_val("reset busy", 16'h0000, {15'h0000, busy});
        check_val("reset addr", IDLE_ADDR, bus.addr);
        check_regs("reset regs", 24'h00_0000, regs);
        $display("test reset during multiply ended");
        repeat (12) foreach (OPS[i]) run_op(OPS[i], OPS[i][7:4] == 4'h6 && $urandom_range(1), 24'($urandom),
            8'($urandom));
        test_done;
    end
endmodule : test_shift_multiply_negate_unit
